// File: bench/smc_client_model.sv
////////////////////////////////////////////////////////////
// Behavioural register client at the far end of the two-wire bus.
// It only pulls the data line, never the clock line.
module smc_client_model (
	input wire logic scl, // Clock line level
	input wire logic sda, // Data line level
	output logic sda_low // High while pulling data low
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [6:0] OWN_ADDR = 7'h57;
	typedef enum logic [2:0] {
		CS_IDLE,
		CS_ADDR,
		CS_REG,
		CS_WDATA,
		CS_RDATA,
		CS_IGN
	} smc_cstate_type;

	// Time-outs stay off, nothing here ever clears this bit
	logic timeout_disable = 1'b1;
	smc_cstate_type state_ff = CS_IDLE;
	logic [7:0] mem_ff [256];
	logic [7:0] ptr_ff = 8'h00;
	logic [7:0] rx_ff = 8'h00;
	logic [7:0] tx_ff = 8'h00;
	int bit_ff = 0;
	logic rd_first_ff = 1'b0;
	logic host_ack_ff = 1'b0;
	logic is_send_ff = 1'b0;
	logic prev_send_ff = 1'b0;

	// Known contents so the bench can work out every read
	initial
	begin
		sda_low = 1'b0;
		for (int i = 0; i < 256; i++)
			mem_ff[i] = 8'(i) ^ 8'hC3;
	end

	////////////////////////////////////////////////////////////
	// Start and repeated start restart the byte count
	always @(negedge sda)
	begin
		if (scl === 1'b1)
		begin
			state_ff = CS_ADDR;
			bit_ff = -1;
			is_send_ff = 1'b0;
			sda_low = 1'b0;
		end
	end

	// Stop ends any transaction; a lone pointer load is remembered
	always @(posedge sda)
	begin
		if (scl === 1'b1)
		begin
			prev_send_ff = is_send_ff;
			is_send_ff = 1'b0;
			state_ff = CS_IDLE;
			sda_low = 1'b0;
		end
	end

	// Sample on the rising clock; no rate dependence at all
	always @(posedge scl)
	begin
		if (state_ff == CS_RDATA && bit_ff == 8)
			host_ack_ff = (sda === 1'b0);
		else if (state_ff != CS_IDLE && bit_ff >= 0 && bit_ff < 8)
			rx_ff = {rx_ff[6:0], sda};
	end

	task automatic ack_byte();
		if (state_ff == CS_RDATA)
			sda_low = 1'b0;
		case (state_ff)
			CS_ADDR:
			begin
				// A write right after a pointer load is refused
				if (rx_ff[7:1] == OWN_ADDR &&
					!(rx_ff[0] == 1'b0 && prev_send_ff))
				begin
					sda_low = 1'b1;
					state_ff = rx_ff[0] ? CS_RDATA : CS_REG;
					rd_first_ff = 1'b1;
				end
				else
					state_ff = CS_IGN;
			end
			CS_REG:
			begin
				sda_low = 1'b1;
				ptr_ff = rx_ff;
				is_send_ff = 1'b1;
				state_ff = CS_WDATA;
			end
			CS_WDATA:
			begin
				sda_low = 1'b1;
				mem_ff[ptr_ff] = rx_ff;
				ptr_ff = ptr_ff + 8'h01;
				is_send_ff = 1'b0;
			end
			default:
				;
		endcase
	endtask

	task automatic next_read();
		if (!rd_first_ff && !host_ack_ff)
			state_ff = CS_IGN;
		else
		begin
			if (!rd_first_ff)
				ptr_ff = ptr_ff + 8'h01;
			rd_first_ff = 1'b0;
			tx_ff = mem_ff[ptr_ff];
			sda_low = ~tx_ff[7];
		end
	endtask

	// Data changes only while the clock is low
	always @(negedge scl)
	begin
		if (state_ff != CS_IDLE)
		begin
			if (bit_ff == 7)
			begin
				bit_ff = 8;
				ack_byte();
			end
			else if (bit_ff == 8)
			begin
				bit_ff = 0;
				sda_low = 1'b0;
				if (state_ff == CS_RDATA)
					next_read();
			end
			else
			begin
				bit_ff = bit_ff + 1;
				if (state_ff == CS_RDATA)
					sda_low = ~tx_ff[7 - bit_ff];
			end
		end
	end
endmodule

// File: bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// Short stall limit; data is always offered ahead of the wait
	localparam int STALL_SIM = 50;
	// Seven transactions at 400 kHz take about 130k cycles
	localparam int CYC_LIMIT = 140000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic wr_valid = 1'b0;
	smc_pkg::smc_kind_type cmd_kind = smc_pkg::KIND_SEND_BYTE;
	logic [7:0] cmd_reg = 8'h00;
	logic [7:0] cmd_len = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic cmd_ready, wr_ready, rd_valid, done, nack_err, abort_err;
	logic [7:0] rd_data, ptr_mirror;
	logic scl_out, scl_oe, sda_out, sda_oe, cl_low;
	wire scl_w, sda_w;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	int low_cyc = 0;
	integer seed = 32'h9a5e3735;
	logic [7:0] exp_q [$];
	logic [7:0] d0, d1, d2;

	// Pull-ups: a line is low only while some party pulls it
	// The host's drive value is used, so a wrong one breaks the bus
	assign scl_w = scl_oe ? scl_out : 1'b1;
	assign sda_w = cl_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

	always #2 clk = ~clk;

	smc_host #(.STALL_LIMIT(STALL_SIM)) DUT (.clk(clk), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_reg(cmd_reg),
		.cmd_len(cmd_len), .cmd_ready(cmd_ready), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .done(done), .nack_err(nack_err),
		.abort_err(abort_err), .ptr_mirror(ptr_mirror), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe));

	smc_client_model client (.scl(scl_w), .sda(sda_w), .sda_low(cl_low));

	////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Client contents before any write, worked out independently
	function automatic logic [7:0] init_val(input logic [7:0] a);
		return a ^ 8'hC3;
	endfunction

	// One whole transaction; returns in the cycle of the done pulse
	task automatic run_cmd(input smc_pkg::smc_kind_type kind,
		input logic [7:0] rg, input logic [7:0] len,
		input logic [7:0] w0, input logic [7:0] w1, input int nwr);
		cmd_kind = kind;
		cmd_reg = rg;
		cmd_len = len;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1)
			@(negedge clk);
		while (cmd_ready !== 1'b0)
			@(negedge clk);
		cmd_valid = 1'b0;
		for (int i = 0; i < nwr; i++)
		begin
			wr_data = (i == 0) ? w0 : w1;
			wr_valid = 1'b1;
			@(negedge clk);
			while (wr_ready !== 1'b1)
				@(negedge clk);
		end
		wr_valid = 1'b0;
		while (done !== 1'b1)
			@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////
	// Every read byte is matched against the oldest note
	always @(negedge clk)
	begin
		if (rd_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(rd_data, 8'hXX);
			else
				check(rd_data, exp_q.pop_front());
		end
	end

	// A host must not hold the clock low for 100 us or more
	always @(negedge clk)
	begin
		low_cyc = (scl_w === 1'b0) ? low_cyc + 1 : 0;
		if (low_cyc == 25000)
			check(8'h01, 8'h00);
	end

	// Hang guard: counts as a mismatch and closes the run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == CYC_LIMIT)
		begin
			errors++;
			finish_test();
		end
	end

	initial
	begin
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		d2 = 8'($random(seed));
		repeat (12) @(negedge clk);
		check({4'h0, cmd_ready, scl_oe, sda_oe, done}, 8'h00);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		// Pointer load, then a second one that the client refuses
		run_cmd(smc_pkg::KIND_SEND_BYTE, 8'hFE, 8'h00, 8'h00, 8'h00, 0);
		check(ptr_mirror, 8'hFE);
		check({7'h00, nack_err}, 8'h00);
		run_cmd(smc_pkg::KIND_SEND_BYTE, 8'h10, 8'h00, 8'h00, 8'h00, 0);
		check({7'h00, nack_err}, 8'h01);
		// Receive byte sees the pointer left by the first load
		exp_q.push_back(init_val(8'hFE));
		run_cmd(smc_pkg::KIND_RECV_BYTE, 8'h10, 8'h00, 8'h00, 8'h00, 0);
		check(ptr_mirror, 8'hFE);
		// Block write across the top of the map
		run_cmd(smc_pkg::KIND_BLOCK_WRITE, 8'hFF, 8'h02, d0, d1, 2);
		check(ptr_mirror, 8'h01);
		check({7'h00, nack_err}, 8'h00);
		run_cmd(smc_pkg::KIND_WRITE_BYTE, 8'h10, 8'h00, d2, 8'h00, 1);
		check(ptr_mirror, 8'h11);
		exp_q.push_back(d2);
		run_cmd(smc_pkg::KIND_READ_BYTE, 8'h10, 8'h00, 8'h00, 8'h00, 0);
		check({7'h00, nack_err}, 8'h00);
		// Block read wraps as well and returns what was written
		exp_q.push_back(d0);
		exp_q.push_back(d1);
		run_cmd(smc_pkg::KIND_BLOCK_READ, 8'hFF, 8'h02, 8'h00, 8'h00, 0);
		check(ptr_mirror, 8'h00);
		check({7'h00, abort_err}, 8'h00);
		@(negedge clk);
		check(8'(exp_q.size()), 8'h00);
		finish_test();
	end
endmodule

// File: verilog/smc_host.sv
//Function
// - Start: data falls while clock high.
// - Stop: data rises while clock high.
// - First byte: 7-bit address, then direction.
// - Bytes are eight bits, MSB first.
// - Host acknowledges reads except the last.
// - Host keeps the clock above 10 kHz.
// - Block transfers carry no byte count.
// - Write byte: address, register, data, stop.
// - Read byte: register, repeated start, read.
// - Block write stores bytes at successive registers.
// - Block read returns successive registers until NACK.
// - Receive byte reads register at current pointer.
module smc_host #(
	parameter int STALL_LIMIT = smc_pkg::STALL_CYC // Clock-low wait limit
) (
	input wire logic clk, // System clock, 250 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic cmd_valid, // Transaction request
	input smc_pkg::smc_kind_type cmd_kind, // Transaction kind
	input wire logic [7:0] cmd_reg, // Register address
	input wire logic [7:0] cmd_len, // Byte count for block kinds
	output logic cmd_ready, // Idle, request may be taken
	input wire logic wr_valid, // Write byte offered
	input wire logic [7:0] wr_data, // Write byte
	output logic wr_ready, // Pulse: write byte taken
	output logic [7:0] rd_data, // Last byte read
	output logic rd_valid, // Pulse: rd_data is new
	output logic done, // Pulse: transaction ended
	output logic nack_err, // Client refused a byte
	output logic abort_err, // Write data came too late
	output logic [7:0] ptr_mirror, // Copy of the client pointer
	input wire logic scl_in, // Clock line level
	output logic scl_out, // Clock line drive value
	output logic scl_oe, // High while pulling the clock low
	input wire logic sda_in, // Data line level
	output logic sda_out, // Data line drive value
	output logic sda_oe // High while pulling data low
);

	smc_pkg::smc_state_type state_ff;
	smc_pkg::smc_step_type step_ff;
	smc_pkg::smc_kind_type kind_ff;
	logic [7:0] qtr_cnt_ff;
	logic [13:0] stall_cnt_ff;
	logic [1:0] phase_ff;
	logic [3:0] bit_idx_ff;
	logic [8:0] shift_ff;
	logic [8:0] rx_ff;
	logic [7:0] reg_ff;
	logic [8:0] remain_ff;
	logic [7:0] ptr_ff;
	logic [7:0] rd_data_ff;
	logic scl_oe_ff;
	logic sda_oe_ff;
	logic cmd_ready_ff;
	logic wr_ready_ff;
	logic rd_valid_ff;
	logic done_ff;
	logic nack_err_ff;
	logic abort_err_ff;
	logic pin_low_ff;
	logic scl_s;
	logic sda_s;
	logic tick;
	logic stretch_wait;
	logic on_bus;

	////////////////////////////////////////////////////////////////////
	function automatic logic kind_is_read(smc_pkg::smc_kind_type k);
		kind_is_read = (k == smc_pkg::KIND_READ_BYTE) ||
			(k == smc_pkg::KIND_RECV_BYTE) ||
			(k == smc_pkg::KIND_BLOCK_READ);
	endfunction

	// Bytes to move after the register byte; block reads need one
	function automatic logic [8:0] kind_len(smc_pkg::smc_kind_type k,
		logic [7:0] len);
		if (k == smc_pkg::KIND_SEND_BYTE)
			kind_len = 9'h000;
		else if (k == smc_pkg::KIND_BLOCK_WRITE)
			kind_len = {1'b0, len};
		else if (k == smc_pkg::KIND_BLOCK_READ && len != 8'h00)
			kind_len = {1'b0, len};
		else
			kind_len = 9'h001;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Line synchroniser and bus watch
	smc_line_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.start_seen(),
		.stop_seen()
	);

	// A released clock still low means someone stretches it: hold time
	assign on_bus = (state_ff == smc_pkg::S_START) ||
		(state_ff == smc_pkg::S_FRAME) || (state_ff == smc_pkg::S_STOP);
	assign stretch_wait = on_bus && !scl_oe_ff && !scl_s;
	assign tick = on_bus && !stretch_wait &&
		(qtr_cnt_ff == smc_pkg::QTR_LAST);

	// Quarter-bit timer for the 400 kHz bus; the client model has no rate limit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			qtr_cnt_ff <= smc_pkg::QTR_RST;
		else if (!on_bus || stretch_wait || tick)
			qtr_cnt_ff <= smc_pkg::QTR_RST;
		else
			qtr_cnt_ff <= qtr_cnt_ff + 8'h01;
	end

	// Bound the clock-low wait for write data, below a 10 kHz half
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stall_cnt_ff <= smc_pkg::STALL_RST;
		else if (state_ff == smc_pkg::S_WAIT_DATA &&
			stall_cnt_ff != 14'(STALL_LIMIT - 1))
			stall_cnt_ff <= stall_cnt_ff + 14'h0001;
		else
			stall_cnt_ff <= smc_pkg::STALL_RST;
	end

	////////////////////////////////////////////////////////////////////
	// Transaction sequencer with the pin drivers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= smc_pkg::S_IDLE;
			step_ff <= smc_pkg::ST_ADDR_W;
			kind_ff <= smc_pkg::KIND_WRITE_BYTE;
			phase_ff <= smc_pkg::PH_FIRST;
			bit_idx_ff <= smc_pkg::IDX_RST;
			shift_ff <= smc_pkg::FRAME_RST;
			rx_ff <= smc_pkg::FRAME_RST;
			reg_ff <= smc_pkg::BYTE_RST;
			remain_ff <= 9'h000;
			ptr_ff <= smc_pkg::BYTE_RST;
			rd_data_ff <= smc_pkg::BYTE_RST;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			cmd_ready_ff <= 1'b0;
			wr_ready_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
			done_ff <= 1'b0;
			nack_err_ff <= 1'b0;
			abort_err_ff <= 1'b0;
		end
		else
		begin
			wr_ready_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
			done_ff <= 1'b0;
			case (state_ff)
			smc_pkg::S_IDLE:
			begin
				cmd_ready_ff <= 1'b1;
				// Only start on a free bus
				if (cmd_valid && cmd_ready_ff && scl_s && sda_s)
				begin
					cmd_ready_ff <= 1'b0;
					kind_ff <= cmd_kind;
					reg_ff <= cmd_reg;
					remain_ff <= kind_len(cmd_kind, cmd_len);
					nack_err_ff <= 1'b0;
					abort_err_ff <= 1'b0;
					phase_ff <= smc_pkg::PH_FIRST;
					// Receive byte skips the register byte
					if (cmd_kind == smc_pkg::KIND_RECV_BYTE)
						step_ff <= smc_pkg::ST_ADDR_R;
					else
						step_ff <= smc_pkg::ST_ADDR_W;
					state_ff <= smc_pkg::S_START;
				end
			end
			smc_pkg::S_START:
			begin
				if (tick)
				begin
					phase_ff <= phase_ff + 2'h1;
					if (phase_ff == smc_pkg::PH_FIRST)
						sda_oe_ff <= 1'b0;
					else if (phase_ff == smc_pkg::PH_SETUP)
						scl_oe_ff <= 1'b0;
					else if (phase_ff == smc_pkg::PH_RISE)
						sda_oe_ff <= 1'b1;
					else
					begin
						scl_oe_ff <= 1'b1;
						// Address first, then the direction bit
						shift_ff <= {smc_pkg::CLIENT_ADDR,
							(step_ff == smc_pkg::ST_ADDR_R) ?
							smc_pkg::DIR_READ : smc_pkg::DIR_WRITE,
							1'b1};
						bit_idx_ff <= smc_pkg::IDX_RST;
						state_ff <= smc_pkg::S_FRAME;
					end
				end
			end
			smc_pkg::S_FRAME:
			begin
				// Nine slots, MSB first; a 1 releases the data line
				if (tick)
				begin
					phase_ff <= phase_ff + 2'h1;
					if (phase_ff == smc_pkg::PH_FIRST)
						sda_oe_ff <= !shift_ff[8];
					else if (phase_ff == smc_pkg::PH_RISE)
						scl_oe_ff <= 1'b0;
					else if (phase_ff == smc_pkg::PH_LAST)
					begin
						rx_ff <= {rx_ff[7:0], sda_s};
						shift_ff <= {shift_ff[7:0], 1'b1};
						scl_oe_ff <= 1'b1;
						if (bit_idx_ff == smc_pkg::ACK_IDX)
							state_ff <= smc_pkg::S_NEXT;
						else
							bit_idx_ff <= bit_idx_ff + 4'h1;
					end
				end
			end
			smc_pkg::S_NEXT:
			begin
				phase_ff <= smc_pkg::PH_FIRST;
				bit_idx_ff <= smc_pkg::IDX_RST;
				if (step_ff != smc_pkg::ST_RDATA && rx_ff[0])
				begin
					// Client refused the byte: end the transaction
					nack_err_ff <= 1'b1;
					state_ff <= smc_pkg::S_STOP;
				end
				else
				begin
					case (step_ff)
					smc_pkg::ST_ADDR_W:
					begin
						shift_ff <= {reg_ff, 1'b1};
						step_ff <= smc_pkg::ST_REG;
						state_ff <= smc_pkg::S_FRAME;
					end
					smc_pkg::ST_REG:
					begin
						ptr_ff <= reg_ff;
						if (kind_is_read(kind_ff))
						begin
							step_ff <= smc_pkg::ST_ADDR_R;
							state_ff <= smc_pkg::S_START;
						end
						else if (remain_ff == 9'h000)
							state_ff <= smc_pkg::S_STOP;
						else
						begin
							// Data follows directly, no count byte
							step_ff <= smc_pkg::ST_WDATA;
							state_ff <= smc_pkg::S_WAIT_DATA;
						end
					end
					smc_pkg::ST_WDATA:
					begin
						// Client pointer steps on each acknowledge
						ptr_ff <= ptr_ff + 8'h01;
						remain_ff <= remain_ff - 9'h001;
						if (remain_ff == 9'h001)
							state_ff <= smc_pkg::S_STOP;
						else
							state_ff <= smc_pkg::S_WAIT_DATA;
					end
					smc_pkg::ST_ADDR_R:
					begin
						shift_ff <= {smc_pkg::BYTE_ONES,
							remain_ff == 9'h001};
						step_ff <= smc_pkg::ST_RDATA;
						state_ff <= smc_pkg::S_FRAME;
					end
					default:
					begin
						rd_data_ff <= rx_ff[8:1];
						rd_valid_ff <= 1'b1;
						remain_ff <= remain_ff - 9'h001;
						if (remain_ff == 9'h001)
							state_ff <= smc_pkg::S_STOP;
						else
						begin
							// Pointer holds on the last byte read
							ptr_ff <= ptr_ff + 8'h01;
							shift_ff <= {smc_pkg::BYTE_ONES,
								remain_ff == 9'h002};
							state_ff <= smc_pkg::S_FRAME;
						end
					end
					endcase
				end
			end
			smc_pkg::S_WAIT_DATA:
			begin
				if (wr_valid)
				begin
					shift_ff <= {wr_data, 1'b1};
					wr_ready_ff <= 1'b1;
					state_ff <= smc_pkg::S_FRAME;
				end
				else if (stall_cnt_ff == 14'(STALL_LIMIT - 1))
				begin
					abort_err_ff <= 1'b1;
					state_ff <= smc_pkg::S_STOP;
				end
			end
			default:
			begin
				// Stop: data low, clock up, then data up
				if (tick)
				begin
					phase_ff <= phase_ff + 2'h1;
					if (phase_ff == smc_pkg::PH_FIRST)
						sda_oe_ff <= 1'b1;
					else if (phase_ff == smc_pkg::PH_SETUP)
						scl_oe_ff <= 1'b0;
					else if (phase_ff == smc_pkg::PH_RISE)
						sda_oe_ff <= 1'b0;
					else
					begin
						done_ff <= 1'b1;
						state_ff <= smc_pkg::S_IDLE;
					end
				end
			end
			endcase
		end
	end

	// Drive value of both open-drain pins is always low
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pin_low_ff <= 1'b0;
		else
			pin_low_ff <= 1'b0;
	end

	assign cmd_ready = cmd_ready_ff;
	assign wr_ready = wr_ready_ff;
	assign rd_data = rd_data_ff;
	assign rd_valid = rd_valid_ff;
	assign done = done_ff;
	assign nack_err = nack_err_ff;
	assign abort_err = abort_err_ff;
	assign ptr_mirror = ptr_ff;
	assign scl_out = pin_low_ff;
	assign sda_out = pin_low_ff;
	assign scl_oe = scl_oe_ff;
	assign sda_oe = sda_oe_ff;

	////////////////////////////////////////////////////////////////////
	// Checks on the bus the host produces
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_last_wdata_acked;
		state_ff == smc_pkg::S_NEXT && step_ff == smc_pkg::ST_WDATA &&
			!rx_ff[0] && remain_ff == 9'h001;
	endsequence
	sequence s_stop_entered;
		state_ff == smc_pkg::S_STOP ##1 state_ff == smc_pkg::S_STOP;
	endsequence

	property p_start_cond;
		$rose(sda_oe_ff) && !scl_oe_ff |-> state_ff == smc_pkg::S_START;
	endproperty
	a_start_cond: assert property (p_start_cond)
		else $error("data fell with clock high outside a start");
	property p_stop_cond;
		$fell(sda_oe_ff) && !scl_oe_ff |-> state_ff == smc_pkg::S_STOP;
	endproperty
	a_stop_cond: assert property (p_stop_cond)
		else $error("data rose with clock high outside a stop");
	property p_addr_byte;
		$past(state_ff) == smc_pkg::S_START &&
			state_ff == smc_pkg::S_FRAME |->
			shift_ff[8:2] == smc_pkg::CLIENT_ADDR && shift_ff[0] &&
			shift_ff[1] == (step_ff == smc_pkg::ST_ADDR_R);
	endproperty
	a_addr_byte: assert property (p_addr_byte)
		else $error("first byte is not address and direction");
	property p_data_stable;
		state_ff == smc_pkg::S_FRAME && !scl_oe_ff && !$past(scl_oe_ff)
			|-> $stable(sda_oe_ff);
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("data changed while clock was released");
	property p_host_ack;
		state_ff == smc_pkg::S_FRAME && step_ff == smc_pkg::ST_RDATA &&
			bit_idx_ff == smc_pkg::ACK_IDX && phase_ff == smc_pkg::PH_RISE
			|-> sda_oe_ff == (remain_ff != 9'h001);
	endproperty
	a_host_ack: assert property (p_host_ack)
		else $error("wrong acknowledge after a read byte");
	property p_stall_bound;
		stall_cnt_ff < 14'(STALL_LIMIT);
	endproperty
	a_stall_bound: assert property (p_stall_bound)
		else $error("clock held low past the stall limit");
	property p_no_count;
		state_ff == smc_pkg::S_NEXT && step_ff == smc_pkg::ST_REG &&
			!rx_ff[0] && !kind_is_read(kind_ff) && remain_ff != 9'h000
			|=> state_ff == smc_pkg::S_WAIT_DATA;
	endproperty
	a_no_count: assert property (p_no_count)
		else $error("register byte not followed by data");
	property p_write_ends;
		s_last_wdata_acked |=> s_stop_entered;
	endproperty
	a_write_ends: assert property (p_write_ends)
		else $error("last write byte not followed by stop");
	property p_done_after_stop;
		done_ff |-> $past(state_ff) == smc_pkg::S_STOP && !sda_oe_ff &&
			!scl_oe_ff;
	endproperty
	a_done_after_stop: assert property (p_done_after_stop)
		else $error("done without a finished stop");
	property p_rd_pulse;
		rd_valid_ff |-> $past(state_ff) == smc_pkg::S_NEXT ##1 !rd_valid_ff;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse)
		else $error("read strobe longer than one cycle");

endmodule

// File: verilog/smc_line_sync.sv
////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for both bus lines plus start/stop watch
module smc_line_sync (
	input wire logic clk, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic scl_in, // Raw clock line level
	input wire logic sda_in, // Raw data line level
	output logic scl_s, // Synchronised clock line
	output logic sda_s, // Synchronised data line
	output logic start_seen, // One-cycle pulse on a start condition
	output logic stop_seen // One-cycle pulse on a stop condition
);

	logic [1:0] meta_ff;
	logic [1:0] sync_ff;
	logic [1:0] prev_ff;
	logic start_ff;
	logic stop_ff;

	////////////////////////////////////////////////////////////////////
	// Lines idle high, so reset to high; the first stage feeds only
	// the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= 2'h3;
			sync_ff <= 2'h3;
			prev_ff <= 2'h3;
		end
		else
		begin
			meta_ff <= {scl_in, sda_in};
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// Data edges while the clock stays high mark start and stop
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			start_ff <= 1'b0;
			stop_ff <= 1'b0;
		end
		else
		begin
			start_ff <= prev_ff[1] && sync_ff[1] && prev_ff[0] && !sync_ff[0];
			stop_ff <= prev_ff[1] && sync_ff[1] && !prev_ff[0] && sync_ff[0];
		end
	end

	assign scl_s = sync_ff[1];
	assign sda_s = sync_ff[0];
	assign start_seen = start_ff;
	assign stop_seen = stop_ff;

endmodule

// File: verilog/smc_pkg.sv
package smc_pkg;

	// System clock and bus rate, in kHz
	localparam int CLK_KHZ = 250000;
	localparam int BUS_KHZ = 400;
	// A quarter bit is a least time, so it rounds up
	localparam int QTR_CYC = (CLK_KHZ + 4 * BUS_KHZ - 1) / (4 * BUS_KHZ);
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
	localparam logic [7:0] QTR_RST = 8'h00;

	// Longest time the host may hold the clock low waiting for data
	localparam int STALL_NS = 40000;
	// A longest time rounds down
	localparam int STALL_CYC = (STALL_NS * (CLK_KHZ / 1000)) / 1000;
	localparam logic [13:0] STALL_RST = 14'h0000;

	// Client address and direction bit
	localparam logic [6:0] CLIENT_ADDR = 7'h57;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;

	// Frame shape: eight data bits and one acknowledge slot
	localparam logic [3:0] ACK_IDX = 4'h8;
	localparam logic [3:0] IDX_RST = 4'h0;
	localparam logic [1:0] PH_FIRST = 2'h0;
	localparam logic [1:0] PH_SETUP = 2'h1;
	localparam logic [1:0] PH_RISE = 2'h2;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam logic [8:0] FRAME_RST = 9'h1FF;

	typedef enum logic [2:0] {
		KIND_WRITE_BYTE,
		KIND_READ_BYTE,
		KIND_SEND_BYTE,
		KIND_RECV_BYTE,
		KIND_BLOCK_WRITE,
		KIND_BLOCK_READ
	} smc_kind_type;

	typedef enum logic [2:0] {
		S_IDLE,
		S_START,
		S_FRAME,
		S_NEXT,
		S_WAIT_DATA,
		S_STOP
	} smc_state_type;

	typedef enum logic [2:0] {
		ST_ADDR_W,
		ST_REG,
		ST_WDATA,
		ST_ADDR_R,
		ST_RDATA
	} smc_step_type;

endpackage
